// >>> hw/cctr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module cctr_regs #(
  parameter int TEMP_W = 8,
  parameter int CC_W = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic watchdog_enable,
  input wire logic [TEMP_W-1:0] die_temp_c,
  input wire logic cool_zone_pin,
  input wire logic [CC_W-1:0] fast_charge_current_setting,
  output logic settings_unlocked,
  output logic watchdog_restart,
  output logic thermal_regulation_flag,
  output logic current_foldback,
  output logic shipping_mode,
  output cctr_pkg::cctr_adjust_type adjust,
  output logic [CC_W-1:0] effective_charge_current
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // full eight-bit match, so no other address aliases onto the pair
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  cctr_pkg::cctr_prot_wdog_type pw_q;
  cctr_pkg::cctr_therm_ship_type ts_q;
  cctr_pkg::cctr_prot_wdog_type pw_wr;
  cctr_pkg::cctr_therm_ship_type ts_wr;
  // strobes only count with ce high, so a frozen block ignores the bus
  wire hit_pw = reg_hit(reg_addr, cctr_pkg::CCTR_PROT_WDOG_OFFSET);
  wire hit_ts = reg_hit(reg_addr, cctr_pkg::CCTR_THERM_SHIP_OFFSET);
  wire wr_pw = ce && reg_wr && hit_pw;
  wire wr_ts = ce && reg_wr && hit_ts;
  // write data viewed through each register layout
  assign pw_wr = cctr_pkg::cctr_prot_wdog_type'(reg_wdata);
  assign ts_wr = cctr_pkg::cctr_therm_ship_type'(reg_wdata);

  // unmapped reads give a fixed pattern rather than aliasing a register
  wire [7:0] rd_pw = pw_q;
  wire [7:0] rd_ts = ts_q;
  wire [7:0] rd_mux = hit_pw ? rd_pw : (hit_ts ? rd_ts : cctr_pkg::CCTR_UNMAPPED_READ);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  // every field is read/write, spare and reserved bits included
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pw_q <= cctr_pkg::CCTR_PROT_WDOG_RESET;
    end else if (wr_pw) begin
      pw_q <= pw_wr;
    end
  end

  // the fields of this one steer the thermal logic and the shipping mode output below
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ts_q <= cctr_pkg::CCTR_THERM_SHIP_RESET; // R8 R10 R11
    end else if (wr_ts) begin
      ts_q <= ts_wr;
    end
  end

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  // named taps keep the thermal logic free of struct paths
  wire profile_on = ts_q.temp_profile_enable;
  wire [3:0] setpoint_code = ts_q.junction_temp_setpoint;
  wire cv_reduce_bit = ts_q.cool_zone_voltage_reduce;
  wire cc_halve_bit = ts_q.cool_zone_current_halve;
  wire ship_bit = ts_q.shipping_mode_enable;

  // answer one cycle after the strobe; a read beside a write sees the old value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
    end
  end

  // data holds until the next read, so a slow host can still pick it up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // write protection and watchdog kick
  // ----------------------------------------------------------------
  // lock state follows the last key write, not the stored field alone
  wire key_ok = pw_wr.settings_write_key == cctr_pkg::CCTR_KEY_UNLOCK;
  wire kick = wr_pw && watchdog_enable &&
              (pw_wr.watchdog_kick_code == cctr_pkg::CCTR_KICK_CODE); // R3 R4

  // reset leaves the protected settings locked until a key arrives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settings_unlocked <= 1'b0;
    end else if (wr_pw) begin
      settings_unlocked <= key_ok; // R1 R2
    end
  end

  // pulse of one ce-enabled cycle, held while ce is low; the timer itself lives outside this block
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_restart <= 1'b0;
    end else if (ce) begin
      watchdog_restart <= kick; // R3
    end
  end

  // ----------------------------------------------------------------
  // thermistor zone synchroniser
  // ----------------------------------------------------------------
  // comparator output is asynchronous; first stage feeds only the second
  logic cool_meta_q;
  logic cool_sync_q;
  // first stage may go metastable; nothing but the second stage reads it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cool_meta_q <= 1'b0;
    end else if (ce) begin
      cool_meta_q <= cool_zone_pin;
    end
  end

  // second stage is the only zone value the logic may use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cool_sync_q <= 1'b0;
    end else if (ce) begin
      cool_sync_q <= cool_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // junction temperature foldback
  // ----------------------------------------------------------------
  // the decoded threshold stays internal; only the compare result leaves,
  // so the regulation loop never sees a code it could misread
  logic over_thr;
  cctr_thermal #(
    .TEMP_W(TEMP_W)
  ) u_thermal (
    .setpoint_code(setpoint_code),
    .die_temp_c(die_temp_c),
    .threshold_c(),
    .over_threshold(over_thr)
  );

  // ----------------------------------------------------------------
  // temperature profile adjustments
  // ----------------------------------------------------------------
  // one gate for every zone adjustment keeps them on the same condition
  function automatic logic zone_gate(input logic zone, input logic enable_bit);
    return zone && enable_bit;
  endfunction

  // profile off forces every adjustment inactive regardless of zone
  wire cool_active = zone_gate(cool_sync_q, profile_on); // R5 R6
  cctr_pkg::cctr_adjust_type adj_d;
  assign adj_d = '{
    cc_halve: zone_gate(cool_active, cc_halve_bit), // R10
    cv_reduce: zone_gate(cool_active, cv_reduce_bit), // R9
    cv_from_zone_settings: profile_on // R12
  };
  // halving by shift truncates odd codes downward, the safe direction
  wire [CC_W-1:0] cc_d = adj_d.cc_halve ?
                         (fast_charge_current_setting >> 1) :
                         fast_charge_current_setting; // R10

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // flag and foldback share one compare, so they can never disagree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thermal_regulation_flag <= 1'b0;
      current_foldback <= 1'b0;
    end else if (ce) begin
      thermal_regulation_flag <= over_thr; // R7
      current_foldback <= over_thr; // R7
    end
  end

  // plain copy of the bit; entry sequencing lives in the power stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shipping_mode <= 1'b0;
    end else if (ce) begin
      shipping_mode <= ship_bit; // R11
    end
  end

  // adjustments lag the synchronised zone by one more edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adjust <= '0;
    end else if (ce) begin
      adjust <= adj_d; // R5 R6 R9
    end
  end

  // follows the setting on every edge with ce high, so a new code needs no strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      effective_charge_current <= '0;
    end else if (ce) begin
      effective_charge_current <= cc_d; // R10
    end
  end

endmodule
`default_nettype wire

// >>> pkg/cctr_pkg.sv
// Functional notes
// R1 - key code 11 unlocks protected register writes
// R2 - any other key code locks them
// R3 - kick code 01 restarts enabled watchdog
// R4 - kick codes 00, 10, 11 do nothing
// R5 - profile off: current and voltage ignore temperature
// R6 - profile on: adjust by thermistor zone
// R7 - over setpoint: fold back current, set flag
// R8 - setpoint 85C plus 5C per code, reset 6
// R9 - cool zone bit2: voltage minus 180mV/cell
// R10 - cool zone bit1: current halved, resets 1
// R11 - bit0 drives shipping mode, resets 0
// R12 - profile off: programmed voltage; on: zone settings
// R13 - setpoint codes above 9 clamp to 130C
`default_nettype none
package cctr_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CCTR_PROT_WDOG_OFFSET = 8'h1C;
  localparam logic [7:0] CCTR_THERM_SHIP_OFFSET = 8'h1D;
  localparam logic [7:0] CCTR_PROT_WDOG_RESET = 8'h00;
  localparam logic [7:0] CCTR_THERM_SHIP_RESET = 8'h32;
  localparam logic [7:0] CCTR_UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // field codes and decode constants
  // ----------------------------------------------------------------
  localparam logic [1:0] CCTR_KEY_UNLOCK = 2'h3;
  localparam logic [1:0] CCTR_KICK_CODE = 2'h1;
  localparam logic [3:0] CCTR_SETPOINT_MAX_CODE = 4'h9;
  localparam logic [7:0] CCTR_SETPOINT_BASE_C = 8'h55;
  localparam logic [7:0] CCTR_SETPOINT_STEP_C = 8'h05;
  localparam logic [7:0] CCTR_CV_COOL_DROP_MV_PER_CELL = 8'hB4;

  // ----------------------------------------------------------------
  // register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic spare_bit_high;
    logic [1:0] reserved;
    logic spare_bit_mid;
    logic [1:0] settings_write_key;
    logic [1:0] watchdog_kick_code;
  } cctr_prot_wdog_type;

  typedef struct packed {
    logic temp_profile_enable;
    logic [3:0] junction_temp_setpoint;
    logic cool_zone_voltage_reduce;
    logic cool_zone_current_halve;
    logic shipping_mode_enable;
  } cctr_therm_ship_type;

  // charge adjustments handed to the regulation loops
  typedef struct packed {
    logic cc_halve;
    logic cv_reduce;
    logic cv_from_zone_settings;
  } cctr_adjust_type;

endpackage
`default_nettype wire

// >>> hw/cctr_thermal.sv
`timescale 1ns/1ps
`default_nettype none
module cctr_thermal #(
  parameter int TEMP_W = 8
) (
  input wire logic [3:0] setpoint_code,
  input wire logic [TEMP_W-1:0] die_temp_c,
  output logic [TEMP_W-1:0] threshold_c,
  output logic over_threshold
);

  // ----------------------------------------------------------------
  // setpoint decode
  // ----------------------------------------------------------------
  // undefined codes clamp so the threshold is always a real temperature
  wire over_max = setpoint_code > cctr_pkg::CCTR_SETPOINT_MAX_CODE; // R13
  wire [3:0] code_used = over_max ? cctr_pkg::CCTR_SETPOINT_MAX_CODE : setpoint_code;
  wire [7:0] step_sum = 8'(code_used * cctr_pkg::CCTR_SETPOINT_STEP_C);
  wire [7:0] thr8 = 8'(cctr_pkg::CCTR_SETPOINT_BASE_C + step_sum); // R8

  assign threshold_c = TEMP_W'(thr8);
  // strictly greater than: sitting exactly at setpoint does not fold back
  assign over_threshold = die_temp_c > threshold_c; // R7

endmodule
`default_nettype wire

// >>> tb/cctr_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// port checks for the protect and thermal registers
// ------------------------------------------------
module cctr_regs_sva #(
  parameter int TEMP_W = 8,
  parameter int CC_W = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic watchdog_enable,
  input wire logic [TEMP_W-1:0] die_temp_c,
  input wire logic settings_unlocked,
  input wire logic watchdog_restart,
  input wire logic thermal_regulation_flag,
  input wire logic current_foldback,
  input wire logic shipping_mode,
  input wire cctr_pkg::cctr_adjust_type adjust
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] m_q;
  wire w1c = ce && reg_wr && reg_addr == 8'h1C;
  // codes past 9 clamp, so the threshold never leaves the table
  wire [7:0] thr = (m_q[6:3] > 4'h9) ? 8'h82 : 8'h55 + 8'h05 * m_q[6:3];
  // shadow of 0x1D; frozen with ce like the real one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) m_q <= cctr_pkg::CCTR_THERM_SHIP_RESET;
    else if (ce && reg_wr && reg_addr == 8'h1D) m_q <= reg_wdata;
  end
  a_key_unlocks: assert property (w1c && reg_wdata[3:2] == 2'h3 |=> settings_unlocked)
    else $error("unlock key ignored");
  a_other_locks: assert property (w1c && reg_wdata[3:2] != 2'h3 |=> !settings_unlocked)
    else $error("lock not applied");
  a_kick_restarts: assert property (
    w1c && reg_wdata[1:0] == 2'h1 && watchdog_enable |=> watchdog_restart)
    else $error("kick missed");
  // a pulse held by a low ce is not a fresh restart
  a_no_stray_kick: assert property (
    $past(ce) && watchdog_restart |-> $past(w1c && reg_wdata[1:0] == 2'h1 && watchdog_enable))
    else $error("restart without kick");
  // the output only follows the bit on an edge with ce high
  a_ship_follows: assert property (
    $past(ce) && m_q[0] == $past(m_q[0]) |-> shipping_mode == m_q[0])
    else $error("ship mode differs from bit");
  a_flag_over_setpoint: assert property (
    ce |=> thermal_regulation_flag == $past(die_temp_c > thr) &&
    current_foldback == thermal_regulation_flag)
    else $error("thermal flag wrong");
  a_profile_off_flat: assert property (ce && !m_q[7] |=> adjust == 3'h0)
    else $error("adjust active with profile off");
  a_halve_needs_bit: assert property (adjust.cc_halve |-> $past(m_q[7] && m_q[1]))
    else $error("halve without profile and bit");
endmodule
bind cctr_regs cctr_regs_sva #(.TEMP_W(TEMP_W), .CC_W(CC_W)) u_sva (.clk, .rst_n, .ce, .reg_wr,
  .reg_addr, .reg_wdata, .watchdog_enable, .die_temp_c, .settings_unlocked, .watchdog_restart,
  .thermal_regulation_flag, .current_foldback, .shipping_mode, .adjust);
`default_nettype wire

// >>> tb/charger_config_protect_thermal_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// random and corner tests at the register port
// ------------------------------------------------
module charger_config_protect_thermal_regs_test;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic watchdog_enable = 1'b0, cool_zone_pin = 1'b0, h;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, die_temp_c = 8'h00, d, reg_rdata;
  logic [6:0] fast_charge_current_setting = 7'h00, effective_charge_current;
  logic reg_rvalid, settings_unlocked, watchdog_restart, thermal_regulation_flag;
  logic current_foldback, shipping_mode;
  cctr_pkg::cctr_adjust_type adjust;
  int n_errors = 0;
  int compares = 0;
  cctr_regs u_dut (.clk, .rst_n, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .watchdog_enable, .die_temp_c, .cool_zone_pin, .fast_charge_current_setting,
    .settings_unlocked, .watchdog_restart, .thermal_regulation_flag, .current_foldback,
    .shipping_mode, .adjust, .effective_charge_current);
  always #12.5 clk = ~clk;
  function automatic logic [7:0] thr(input logic [3:0] c);
    return (c > 4'h9) ? 8'h82 : 8'h55 + 8'h05 * c;
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // strobes rise at a falling edge and drop after the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    check("rvalid", {7'h00, reg_rvalid}, 8'h01);
    check("rdata", reg_rdata, v);
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // a hang costs at most 200 us, far past the few hundred cycles needed
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h9b19));
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    rd(8'h1C, cctr_pkg::CCTR_PROT_WDOG_RESET);
    rd(8'h1D, cctr_pkg::CCTR_THERM_SHIP_RESET);
    rd(8'h40, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      watchdog_enable = i[2];
      wr(8'h1C, {4'h0, i[1:0], i[1:0]});
      check("restart", {7'h00, watchdog_restart}, {7'h00, i[2:0] == 3'h5});
      check("unlocked", {7'h00, settings_unlocked}, {7'h00, i[1:0] == 2'h3});
    end
    rd(8'h1C, 8'h0F);
    $display("test key and kick done");
    // every setpoint code, die temperature around its threshold
    for (int n = 0; n < 32; n++) begin
      d = 8'($urandom);
      d[6:3] = n[3:0];
      cool_zone_pin = 1'($urandom);
      fast_charge_current_setting = 7'($urandom);
      die_temp_c = thr(d[6:3]) - 8'h01 + 8'($urandom % 3);
      h = d[7] & cool_zone_pin & d[1];
      wr(8'h1D, d);
      rd(8'h1D, d);
      repeat (3) @(negedge clk);
      check("ship", {7'h00, shipping_mode}, {7'h00, d[0]});
      check("flag", {6'h00, thermal_regulation_flag, current_foldback},
        {6'h00, {2{die_temp_c > thr(d[6:3])}}});
      check("adjust", {5'h00, adjust},
        {5'h00, h, d[7] & cool_zone_pin & d[2], d[7]});
      check("current", {1'b0, effective_charge_current},
        {1'b0, h ? fast_charge_current_setting >> 1 : fast_charge_current_setting});
    end
    $display("test thermal done");
    ce = 1'b0;
    wr(8'h1D, ~d);
    ce = 1'b1;
    rd(8'h1D, d);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd(8'h1D, cctr_pkg::CCTR_THERM_SHIP_RESET);
    check("relock", {7'h00, settings_unlocked}, 8'h00);
    $display("test freeze and reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
